// ### rtl/eirq_unit.sv
// external interrupt request pin unit with APB register access
//
// Overview of operation
// - pull device on while pin enabled and pull-disable clear; off when set
// - polarity 0 selects falling/low, 1 selects rising/high detection
// - rising polarity gets pull-down, falling polarity gets pull-up
// - pin acts as interrupt input only while pin-enable is 1
// - event flag set on qualifying edge or level; reads 0 when idle
// - writing 1 to acknowledge clears flag; writing 0 ignored; reads 0
// - in edge-and-level mode acknowledge cannot clear flag while pin asserted
// - request enable gates the flag onto the interrupt request
// - mode 0 edge only; mode 1 edges plus sustained levels
//
// Chosen here: the register addresses and register access over APB.
`timescale 1ns/1ns
`include "eirq_map.svh"
module eirq_unit (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        irq_pin,
  output logic             pull_enable,
  output logic             pull_up,
  output logic             pull_down,
  output logic             irq_req,
  output logic             irq_out
);
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic addr_hit(input logic [11:0] a, input logic [11:0] r);
    addr_hit = (a == r);
  endfunction : addr_hit

  eirq_pkg::eirq_state_t st_r;
  eirq_pkg::eirq_state_t st_nxt;

  logic pin_lvl;
  logic pin_rise;
  logic pin_fall;
  logic acc;
  logic wr;
  logic rd;
  logic wr_lane0;
  logic mapped;
  logic asserted_lvl;
  logic edge_hit;
  logic event_hit;
  logic ack_wr;
  logic ctl_wr;
  logic ack_blocked;
  logic [`EIRQ_NEV-1:0] ev_set;

  eirq_pin_sync u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .pin_in  (irq_pin),
    .level   (pin_lvl),
    .rise    (pin_rise),
    .fall    (pin_fall)
  );

  ////////////////////////////////////////////////////////////////////////////
  // bus decode; zero wait states for writes, one for reads
  assign acc      = psel & penable;
  assign wr       = acc & pwrite;
  assign rd       = acc & ~pwrite;
  assign wr_lane0 = wr & pstrb[0];
  assign mapped   = addr_hit(paddr, `EIRQ_ADDR_STATCTL) | addr_hit(paddr, `EIRQ_ADDR_EVSTAT) |
                    addr_hit(paddr, `EIRQ_ADDR_EVEN) | addr_hit(paddr, `EIRQ_ADDR_EVCLR);
  assign ctl_wr   = wr_lane0 & addr_hit(paddr, `EIRQ_ADDR_STATCTL);

  ////////////////////////////////////////////////////////////////////////////
  // detection
  assign asserted_lvl = pin_lvl ~^ st_r.polarity_select;
  assign edge_hit     = st_r.polarity_select ? pin_rise : pin_fall;
  assign event_hit    = st_r.pin_function_enable &
                        (edge_hit | (st_r.edge_level_mode & asserted_lvl));
  assign ack_wr       = wr_lane0 & addr_hit(paddr, `EIRQ_ADDR_STATCTL) &
                        pwdata[`EIRQ_BIT_ACK];
  assign ack_blocked  = ack_wr & st_r.edge_level_mode & st_r.pin_function_enable &
                        asserted_lvl;

  assign ev_set[`EIRQ_EV_PIN]    = event_hit;
  assign ev_set[`EIRQ_EV_ACKBLK] = ack_blocked;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_nxt        = st_r;
    st_nxt.prdata = st_r.prdata;
    st_nxt.rd_wait = rd & ~st_r.rd_wait;
    // a new event in the acknowledge cycle wins over the clear
    if (ack_wr) begin
      st_nxt.event_flag = 1'b0;
    end
    if (event_hit) begin
      st_nxt.event_flag = 1'b1;
    end
    if (wr_lane0 && addr_hit(paddr, `EIRQ_ADDR_STATCTL)) begin
      st_nxt.pull_disable        = pwdata[`EIRQ_BIT_PDD];
      st_nxt.polarity_select     = pwdata[`EIRQ_BIT_EDG];
      st_nxt.pin_function_enable = pwdata[`EIRQ_BIT_PE];
      st_nxt.request_enable      = pwdata[`EIRQ_BIT_IE];
      st_nxt.edge_level_mode     = pwdata[`EIRQ_BIT_MOD];
    end
    if (wr_lane0 && addr_hit(paddr, `EIRQ_ADDR_EVEN)) begin
      st_nxt.ev_enable = pwdata[`EIRQ_NEV-1:0];
    end
    if (wr_lane0 && addr_hit(paddr, `EIRQ_ADDR_EVCLR)) begin
      st_nxt.ev_status = st_r.ev_status & ~pwdata[`EIRQ_NEV-1:0];
    end
    st_nxt.ev_status = st_nxt.ev_status | ev_set;
    if (rd) begin
      st_nxt.prdata = 32'h0000_0000;
      case (paddr)
        `EIRQ_ADDR_STATCTL: begin
          st_nxt.prdata[`EIRQ_BIT_PDD]  = st_r.pull_disable;
          st_nxt.prdata[`EIRQ_BIT_EDG]  = st_r.polarity_select;
          st_nxt.prdata[`EIRQ_BIT_PE]   = st_r.pin_function_enable;
          st_nxt.prdata[`EIRQ_BIT_FLAG] = st_r.event_flag;
          st_nxt.prdata[`EIRQ_BIT_IE]   = st_r.request_enable;
          st_nxt.prdata[`EIRQ_BIT_MOD]  = st_r.edge_level_mode;
        end
        `EIRQ_ADDR_EVSTAT: begin
          st_nxt.prdata[`EIRQ_NEV-1:0] = st_r.ev_status;
        end
        `EIRQ_ADDR_EVEN: begin
          st_nxt.prdata[`EIRQ_NEV-1:0] = st_r.ev_enable;
        end
        default: begin
          st_nxt.prdata = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data is registered, so a read access phase takes one extra cycle; writes take none
  assign pready      = ~rd | st_r.rd_wait;
  assign pslverr     = acc & pready & ~mapped;
  assign prdata      = st_r.prdata;
  assign pull_enable = st_r.pin_function_enable & ~st_r.pull_disable;
  assign pull_down   = pull_enable & st_r.polarity_select;
  assign pull_up     = pull_enable & ~st_r.polarity_select;
  assign irq_req     = st_r.request_enable & st_r.event_flag;
  assign irq_out     = |(st_r.ev_status & st_r.ev_enable);

  ////////////////////////////////////////////////////////////////////////////
  property p_pull_dir;
    @(posedge pclk) disable iff (!presetn)
      pull_enable |-> (pull_up != pull_down) && (pull_down == st_r.polarity_select);
  endproperty
  a_pull_dir: assert property (p_pull_dir) else $error("pull direction wrong");

  property p_pull_en;
    @(posedge pclk) disable iff (!presetn)
      (ctl_wr && pwdata[`EIRQ_BIT_PE] && !pwdata[`EIRQ_BIT_PDD]) |=> pull_enable;
  endproperty
  a_pull_en: assert property (p_pull_en) else $error("pull enable wrong");

  property p_event_sets;
    @(posedge pclk) disable iff (!presetn)
      event_hit |=> st_r.event_flag;
  endproperty
  a_event_sets: assert property (p_event_sets) else $error("flag not set");

  property p_no_spurious;
    @(posedge pclk) disable iff (!presetn)
      (!st_r.event_flag && !event_hit) |=> !st_r.event_flag;
  endproperty
  a_no_spurious: assert property (p_no_spurious) else $error("flag set no event");

  property p_disabled_quiet;
    @(posedge pclk) disable iff (!presetn)
      !st_r.pin_function_enable |-> !event_hit;
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet) else $error("event while off");

  property p_ack_clears;
    @(posedge pclk) disable iff (!presetn)
      (ack_wr && !event_hit) |=> !st_r.event_flag;
  endproperty
  a_ack_clears: assert property (p_ack_clears) else $error("ack did not clear");

  property p_level_holds;
    @(posedge pclk) disable iff (!presetn)
      (st_r.pin_function_enable && st_r.edge_level_mode && asserted_lvl && ack_wr)
        |=> st_r.event_flag;
  endproperty
  a_level_holds: assert property (p_level_holds) else $error("ack cleared at level");

  property p_req;
    @(posedge pclk) disable iff (!presetn)
      $rose(st_r.event_flag) && st_r.request_enable |-> irq_req;
  endproperty
  a_req: assert property (p_req) else $error("no request");

  property p_edge_only;
    @(posedge pclk) disable iff (!presetn)
      (!st_r.edge_level_mode && !edge_hit) |-> !event_hit;
  endproperty
  a_edge_only: assert property (p_edge_only) else $error("level event in edge mode");

  property p_ack_reads0;
    @(posedge pclk) disable iff (!presetn)
      (rd && addr_hit(paddr, `EIRQ_ADDR_STATCTL)) |=> !prdata[`EIRQ_BIT_ACK];
  endproperty
  a_ack_reads0: assert property (p_ack_reads0) else $error("ack bit read 1");

  ////////////////////////////////////////////////////////////////////////////
  // checks driven from control writes and the pin, not from the output terms

  property p_pull_off;
    @(posedge pclk) disable iff (!presetn)
      (ctl_wr && (!pwdata[`EIRQ_BIT_PE] || pwdata[`EIRQ_BIT_PDD]))
        |=> !pull_enable && !pull_up && !pull_down;
  endproperty
  a_pull_off: assert property (p_pull_off) else $error("pull left on");

  property p_pd_rise;
    @(posedge pclk) disable iff (!presetn)
      (ctl_wr && pwdata[`EIRQ_BIT_PE] && !pwdata[`EIRQ_BIT_PDD] && pwdata[`EIRQ_BIT_EDG])
        |=> pull_down && !pull_up;
  endproperty
  a_pd_rise: assert property (p_pd_rise) else $error("no pull-down for rising");

  property p_pu_fall;
    @(posedge pclk) disable iff (!presetn)
      (ctl_wr && pwdata[`EIRQ_BIT_PE] && !pwdata[`EIRQ_BIT_PDD] && !pwdata[`EIRQ_BIT_EDG])
        |=> pull_up && !pull_down;
  endproperty
  a_pu_fall: assert property (p_pu_fall) else $error("no pull-up for falling");

  property p_fall_event;
    @(posedge pclk) disable iff (!presetn)
      (st_r.pin_function_enable && !st_r.polarity_select && pin_fall) |=> st_r.event_flag;
  endproperty
  a_fall_event: assert property (p_fall_event) else $error("falling edge missed");

  property p_wrong_edge;
    @(posedge pclk) disable iff (!presetn)
      (!st_r.edge_level_mode && !st_r.polarity_select && !pin_fall && !st_r.event_flag)
        |=> !st_r.event_flag;
  endproperty
  a_wrong_edge: assert property (p_wrong_edge) else $error("flag without falling edge");

  property p_level_event;
    @(posedge pclk) disable iff (!presetn)
      (st_r.pin_function_enable && st_r.edge_level_mode && (pin_lvl == st_r.polarity_select))
        |=> st_r.event_flag;
  endproperty
  a_level_event: assert property (p_level_event) else $error("level missed");

  property p_sync_rise;
    @(posedge pclk) disable iff (!presetn)
      pin_rise |-> $past(irq_pin, 3) && $past(irq_pin, 4);
  endproperty
  a_sync_rise: assert property (p_sync_rise) else $error("rise not synchronised");

  property p_sync_fall;
    @(posedge pclk) disable iff (!presetn)
      pin_fall |-> !$past(irq_pin, 3) && !$past(irq_pin, 4);
  endproperty
  a_sync_fall: assert property (p_sync_fall) else $error("fall not synchronised");

  property p_flag_holds;
    @(posedge pclk) disable iff (!presetn)
      (st_r.event_flag && !ack_wr) |=> st_r.event_flag;
  endproperty
  a_flag_holds: assert property (p_flag_holds) else $error("flag lost without ack");

  property p_ev_set;
    @(posedge pclk) disable iff (!presetn)
      event_hit |=> st_r.ev_status[`EIRQ_EV_PIN];
  endproperty
  a_ev_set: assert property (p_ev_set) else $error("pin event status not set");

  property p_blk_set;
    @(posedge pclk) disable iff (!presetn)
      ack_blocked |=> st_r.ev_status[`EIRQ_EV_ACKBLK];
  endproperty
  a_blk_set: assert property (p_blk_set) else $error("refused ack not recorded");

  property p_wr_ready;
    @(posedge pclk) disable iff (!presetn)
      wr |-> pready;
  endproperty
  a_wr_ready: assert property (p_wr_ready) else $error("write stalled");

  property p_rd_wait;
    @(posedge pclk) disable iff (!presetn)
      (psel && !penable && !pwrite) ##1 rd |-> !pready ##1 pready;
  endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");

  property p_no_req;
    @(posedge pclk) disable iff (!presetn)
      (ctl_wr && !pwdata[`EIRQ_BIT_IE]) |=> !irq_req;
  endproperty
  a_no_req: assert property (p_no_req) else $error("request while disabled");

  property p_off_quiet;
    @(posedge pclk) disable iff (!presetn)
      (!st_r.pin_function_enable && !st_r.event_flag) |=> !st_r.event_flag;
  endproperty
  a_off_quiet: assert property (p_off_quiet) else $error("flag set while pin off");

  property p_prdata_stable;
    @(posedge pclk) disable iff (!presetn)
      !rd |=> $stable(prdata);
  endproperty
  a_prdata_stable: assert property (p_prdata_stable) else $error("read data moved");
endmodule : eirq_unit

// ### inc/eirq_map.svh
// register map and field positions of the external interrupt pin unit
`ifndef EIRQ_MAP_SVH
`define EIRQ_MAP_SVH
`define EIRQ_ADDR_STATCTL  12'h000
`define EIRQ_ADDR_EVSTAT   12'h004
`define EIRQ_ADDR_EVEN     12'h008
`define EIRQ_ADDR_EVCLR    12'h00C
`define EIRQ_BIT_PDD       6
`define EIRQ_BIT_EDG       5
`define EIRQ_BIT_PE        4
`define EIRQ_BIT_FLAG      3
`define EIRQ_BIT_ACK       2
`define EIRQ_BIT_IE        1
`define EIRQ_BIT_MOD       0
`define EIRQ_EV_PIN        0
`define EIRQ_EV_ACKBLK     1
`define EIRQ_NEV           2
`define EIRQ_CTL_RST       8'h00
`endif

// ### inc/eirq_pkg.sv
// types of the external interrupt pin unit
package eirq_pkg;
  typedef struct packed {
    logic [2:0] sync;
    logic       prev;
    logic       stable;
  } eirq_sync_t;

  typedef struct packed {
    logic       pull_disable;
    logic       polarity_select;
    logic       pin_function_enable;
    logic       event_flag;
    logic       request_enable;
    logic       edge_level_mode;
    logic [1:0] ev_status;
    logic [1:0] ev_enable;
    logic [31:0] prdata;
    logic        rd_wait;
  } eirq_state_t;
endpackage : eirq_pkg

// ### rtl/eirq_pin_sync.sv
// three-stage pin synchroniser with edge detection
`timescale 1ns/1ns
module eirq_pin_sync (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic pin_in,
  output logic      level,
  output logic      rise,
  output logic      fall
);
  eirq_pkg::eirq_sync_t st_r;
  eirq_pkg::eirq_sync_t st_nxt;

  always_comb begin
    st_nxt      = st_r;
    st_nxt.sync = {st_r.sync[1:0], pin_in};
    // accept a change only once stages two and three agree
    if (st_r.sync[2] == st_r.sync[1]) begin
      st_nxt.stable = st_r.sync[2];
    end
    st_nxt.prev = st_r.stable;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign level = st_r.stable;
  assign rise  = st_r.stable & ~st_r.prev;
  assign fall  = ~st_r.stable & st_r.prev;
endmodule : eirq_pin_sync

// ### tb/eirq_pin_model.sv
// far-side device model driving the external interrupt pin
`timescale 1ns/1ns
module eirq_pin_model (
  input  wire logic pclk,
  input  wire logic drive_en,
  input  wire logic drive_val,
  input  wire logic pull_up,
  input  wire logic pull_down,
  output logic      pin
);
  logic last_r;
  // released and unpulled: no stable level, so show the inverse of the last one
  assign pin = drive_en ? drive_val : pull_up ? 1'b1 : pull_down ? 1'b0 : ~last_r;
  always_ff @(posedge pclk) begin
    last_r <= pin;
  end
endmodule : eirq_pin_model

// ### tb/tb_eirq_unit.sv
// self-checking bench of the external interrupt pin unit
`timescale 1ns/1ns
`include "eirq_map.svh"
module tb_eirq_unit;
  logic        pclk, presetn, psel, penable, pwrite, serr;
  logic [11:0] paddr;
  logic [3:0]  pstrb;
  logic [31:0] pwdata, prdata, junk;
  logic        pready, pslverr, irq_pin, pull_enable, pull_up, pull_down;
  logic        irq_req, irq_out, drive_en, drive_val;
  int          failures, n_tests;
  localparam logic [31:0] FLG = 32'h1 << `EIRQ_BIT_FLAG;
  localparam logic [31:0] ACK = 32'h1 << `EIRQ_BIT_ACK;
  eirq_unit i_eirq_unit (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq_pin(irq_pin), .pull_enable(pull_enable),
    .pull_up(pull_up), .pull_down(pull_down), .irq_req(irq_req), .irq_out(irq_out));
  eirq_pin_model i_eirq_pin_model (.pclk(pclk), .drive_en(drive_en), .drive_val(drive_val),
    .pull_up(pull_up), .pull_down(pull_down), .pin(irq_pin));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish
  task automatic chk32(input string n, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask : chk32
  task automatic chk1(input string n, input logic e, input logic g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("BAD %s exp %b got %b", n, e, g);
    end
  endtask : chk1
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    int i;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      failures++;
      tally_and_finish();
    end else begin
      r = prdata;
      serr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, junk);
  endtask : wr
  task automatic rd(input string n, input logic [11:0] a, input logic [31:0] e);
    logic [31:0] r;
    apb(1'b0, a, 32'h0, r);
    chk32(n, e, r);
  endtask : rd
  task automatic settle;
    repeat (10) @(posedge pclk);
  endtask : settle
  function automatic logic [31:0] cw(input int pdd, edg, pe, ie, md);
    cw = 32'h0;
    cw[`EIRQ_BIT_PDD] = pdd[0];
    cw[`EIRQ_BIT_EDG] = edg[0];
    cw[`EIRQ_BIT_PE]  = pe[0];
    cw[`EIRQ_BIT_IE]  = ie[0];
    cw[`EIRQ_BIT_MOD] = md[0];
  endfunction : cw
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, failures, n_tests} = '0;
    drive_en = 1'b1;
    drive_val = 1'b1;
    pstrb = 4'hF;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd("ctl_reset", `EIRQ_ADDR_STATCTL, 32'h0);
    chk1("pull_en_reset", 1'b0, pull_enable);
    wr(`EIRQ_ADDR_STATCTL, cw(0, 0, 1, 1, 0));
    settle();
    chk1("pull_en", 1'b1, pull_enable);
    chk1("pull_up", 1'b1, pull_up);
    chk1("pull_down", 1'b0, pull_down);
    rd("ctl_idle", `EIRQ_ADDR_STATCTL, cw(0, 0, 1, 1, 0));
    drive_val <= 1'b0;
    settle();
    chk1("req_fall", 1'b1, irq_req);
    rd("ctl_fall", `EIRQ_ADDR_STATCTL, cw(0, 0, 1, 1, 0) | FLG);
    rd("evstat", `EIRQ_ADDR_EVSTAT, 32'h1);
    wr(`EIRQ_ADDR_EVEN, 32'h1);
    settle();
    chk1("irq_on", 1'b1, irq_out);
    wr(`EIRQ_ADDR_EVEN, 32'h0);
    settle();
    chk1("irq_masked", 1'b0, irq_out);
    wr(`EIRQ_ADDR_EVCLR, 32'h1);
    wr(`EIRQ_ADDR_EVEN, 32'h1);
    settle();
    chk1("irq_cleared", 1'b0, irq_out);
    wr(`EIRQ_ADDR_STATCTL, cw(0, 0, 1, 1, 0));
    rd("ack_zero", `EIRQ_ADDR_STATCTL, cw(0, 0, 1, 1, 0) | FLG);
    // pin still low here: edge-only mode must let the ack win
    wr(`EIRQ_ADDR_STATCTL, cw(0, 0, 1, 1, 0) | ACK);
    rd("ack_one", `EIRQ_ADDR_STATCTL, cw(0, 0, 1, 1, 0));
    chk1("req_off", 1'b0, irq_req);
    drive_val <= 1'b1;
    settle();
    rd("rise_ign", `EIRQ_ADDR_STATCTL, cw(0, 0, 1, 1, 0));
    wr(`EIRQ_ADDR_STATCTL, cw(0, 1, 1, 0, 1));
    settle();
    chk1("pd_rise", 1'b1, pull_down);
    chk1("req_gated", 1'b0, irq_req);
    wr(`EIRQ_ADDR_STATCTL, cw(0, 1, 1, 0, 1) | ACK);
    rd("lvl_hold", `EIRQ_ADDR_STATCTL, cw(0, 1, 1, 0, 1) | FLG);
    rd("evstat_blk", `EIRQ_ADDR_EVSTAT, 32'h3);
    drive_val <= 1'b0;
    settle();
    wr(`EIRQ_ADDR_STATCTL, cw(0, 1, 1, 0, 1) | ACK);
    rd("lvl_gone", `EIRQ_ADDR_STATCTL, cw(0, 1, 1, 0, 1));
    wr(`EIRQ_ADDR_STATCTL, cw(1, 1, 1, 0, 1));
    settle();
    chk1("pdd_off", 1'b0, pull_enable);
    wr(`EIRQ_ADDR_STATCTL, cw(0, 0, 0, 1, 0));
    // a clean falling edge with the pin function off must stay unseen
    drive_val <= 1'b1;
    settle();
    drive_val <= 1'b0;
    settle();
    chk1("pe_req", 1'b0, irq_req);
    drive_en <= 1'b0;
    settle();
    chk1("pe_pull", 1'b0, pull_enable);
    rd("pe_off", `EIRQ_ADDR_STATCTL, cw(0, 0, 0, 1, 0));
    drive_en <= 1'b1;
    pstrb <= 4'hE;
    wr(`EIRQ_ADDR_STATCTL, cw(0, 1, 1, 0, 1));
    pstrb <= 4'hF;
    rd("strb_ign", `EIRQ_ADDR_STATCTL, cw(0, 0, 0, 1, 0));
    wr(`EIRQ_ADDR_STATCTL, cw(0, 1, 1, 1, 0));
    @(posedge pclk);
    chk1("pd_pre_rst", 1'b1, pull_down);
    // reset again mid-run: every control bit must drop back
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd("ctl_rearm", `EIRQ_ADDR_STATCTL, 32'h0);
    chk1("pull_rearm", 1'b0, pull_enable);
    rd("unmapped", 12'h010, 32'h0);
    chk1("slverr", 1'b1, serr);
    tally_and_finish();
  end
endmodule : tb_eirq_unit
